// ### hw/clkout_map.svh
`ifndef CLKOUT_MAP_SVH
`define CLKOUT_MAP_SVH

`define AUX_CTRL_ADDR 8'h57
`define PLL_OVR_ADDR 8'h58
`define AUX_CTRL_RESET 8'h00
`define PLL_OVR_RESET 8'h00
`define READ_IDLE 8'h00

`define AUX_EN_BIT 7
`define AUX_SEL_MSB 2
`define AUX_SEL_LSB 0
`define OVR_EN_BIT 7
`define D_SEL_MSB 5
`define D_SEL_LSB 4
`define C_SEL_MSB 3
`define C_SEL_LSB 2
`define SE_SEL_BIT 1
`define PLL_EN_BIT 0

`define SEL_16UI 3'h0
`define SEL_32UI 3'h1
`define SEL_64UI 3'h2
`define SEL_TSTAMP 3'h3

`define DIV_OFF 2'h0
`define DIV_1 2'h1
`define DIV_2 2'h2
`define DIV_4 2'h3
`define LAST_DIV_1 2'h0
`define LAST_DIV_2 2'h1
`define LAST_DIV_4 2'h3
`define CNT_ZERO 2'h0
`define CNT_ONE 2'h1

`define NUM_PINS 6
`define PIN_PLL_EN 0
`define PIN_SE_REF 1
`define PIN_CFG0 2
`define PIN_CFG1 3
`define PIN_REF_CLK 4
`define PIN_TSTAMP 5

`endif

// ### hw/clkout_pkg.sv
package clkout_pkg;
    typedef logic [1:0] div_mode_type;
    typedef logic [7:0] reg_byte_type;
    typedef enum logic [1:0] {
        AUX_SRC_OFF,
        AUX_SRC_SER,
        AUX_SRC_TSTAMP
    } aux_src_type;
endpackage

// ### hw/tick_divider.sv
`timescale 1ns/1ps
`default_nettype none
`include "clkout_map.svh"

module tick_divider
    import clkout_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    input wire logic clr_i,
    input wire div_mode_type mode_i,
    output logic q_o
);

    div_mode_type mode_r;
    logic [1:0] cnt_r;
    logic [1:0] last;
    logic q_r;
    logic hit;

    assign q_o = q_r;

    // A toggle is due at this edge; a mode change waits for it, so a stop
    // never lands on a rising output and leaves it stuck high.
    assign hit = tick_i && mode_r != `DIV_OFF && cnt_r >= last;

    always_comb begin
        unique case (mode_r)
            `DIV_1: last = `LAST_DIV_1;
            `DIV_2: last = `LAST_DIV_2;
            default: last = `LAST_DIV_4;
        endcase
    end

    // A new mode is taken only while the output is low, so a ratio change
    // or a stop never cuts a high phase short or starts an extra one.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_r <= `DIV_OFF;
        end else if (!q_r && !hit) begin
            mode_r <= mode_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_r <= 1'b0;
            cnt_r <= `CNT_ZERO;
        end else if (clr_i) begin
            q_r <= 1'b0;
            cnt_r <= `CNT_ZERO;
        end else if (tick_i && mode_r != `DIV_OFF) begin
            if (cnt_r >= last) begin
                q_r <= ~q_r;
                cnt_r <= `CNT_ZERO;
            end else begin
                cnt_r <= cnt_r + `CNT_ONE;
            end
        end
    end

endmodule
`default_nettype wire

// ### hw/clkout_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "clkout_map.svh"

module clkout_ctrl
    import clkout_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RESETN_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WE_I,
    input wire logic REG_RE_I,
    output logic [7:0] REG_RDATA_O,
    output logic REG_RVALID_O,
    input wire logic PLL_ENABLE_PIN_I,
    input wire logic SINGLE_ENDED_REF_PIN_I,
    input wire logic CLOCK_CONFIG_PIN0_I,
    input wire logic CLOCK_CONFIG_PIN1_I,
    input wire logic PLL_REF_CLOCK_I,
    input wire logic TIMESTAMP_INPUT_I,
    input wire logic SER_TICK_I,
    input wire logic SER_REINIT_I,
    output logic PLL_ENABLE_O,
    output logic SINGLE_ENDED_REF_SELECT_O,
    output logic REF_OUTPUT_C_O,
    output logic REF_OUTPUT_D_O,
    output logic AUX_CLOCK_OUTPUT_O
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_meta_r;
    logic rst_n;

    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [`NUM_PINS-1:0] pin_raw;
    logic [`NUM_PINS-1:0] pin_meta_r;
    logic [`NUM_PINS-1:0] pin_r;
    logic ref_prev_r;
    logic ref_tick;

    assign pin_raw[`PIN_PLL_EN] = PLL_ENABLE_PIN_I;
    assign pin_raw[`PIN_SE_REF] = SINGLE_ENDED_REF_PIN_I;
    assign pin_raw[`PIN_CFG0] = CLOCK_CONFIG_PIN0_I;
    assign pin_raw[`PIN_CFG1] = CLOCK_CONFIG_PIN1_I;
    assign pin_raw[`PIN_REF_CLK] = PLL_REF_CLOCK_I;
    assign pin_raw[`PIN_TSTAMP] = TIMESTAMP_INPUT_I;

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_r <= '0;
            pin_r <= '0;
            ref_prev_r <= 1'b0;
        end else begin
            pin_meta_r <= pin_raw;
            pin_r <= pin_meta_r;
            ref_prev_r <= pin_r[`PIN_REF_CLK];
        end
    end

    // Every edge of the reference is one tick, so toggling each tick is
    // divide by one.
    assign ref_tick = pin_r[`PIN_REF_CLK] ^ ref_prev_r;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg_byte_type aux_ctrl_r;
    reg_byte_type pll_ovr_r;

    // Reserved bits are stored and read back as written.
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            aux_ctrl_r <= `AUX_CTRL_RESET;
        end else if (REG_WE_I && REG_ADDR_I == `AUX_CTRL_ADDR) begin
            aux_ctrl_r <= REG_WDATA_I;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            pll_ovr_r <= `PLL_OVR_RESET;
        end else if (REG_WE_I && REG_ADDR_I == `PLL_OVR_ADDR) begin
            pll_ovr_r <= REG_WDATA_I;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            REG_RDATA_O <= `READ_IDLE;
            REG_RVALID_O <= 1'b0;
        end else begin
            REG_RVALID_O <= REG_RE_I;
            if (REG_RE_I) begin
                unique case (REG_ADDR_I)
                    `AUX_CTRL_ADDR: REG_RDATA_O <= aux_ctrl_r;
                    `PLL_OVR_ADDR: REG_RDATA_O <= pll_ovr_r;
                    default: REG_RDATA_O <= `READ_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // PLL control source
    // ----------------------------------------------------------------
    logic ovr_en;
    logic pll_en_eff;
    logic se_sel_eff;
    div_mode_type c_pin;
    div_mode_type d_pin;
    div_mode_type c_eff;
    div_mode_type d_raw;
    div_mode_type d_eff;

    assign ovr_en = pll_ovr_r[`OVR_EN_BIT];
    // In pin mode the two config pins give C; D copies C when pin1 is set.
    assign c_pin = {pin_r[`PIN_CFG1], pin_r[`PIN_CFG0]};
    assign d_pin = pin_r[`PIN_CFG1] ? c_pin : `DIV_OFF;

    always_comb begin
        if (ovr_en) begin
            pll_en_eff = pll_ovr_r[`PLL_EN_BIT];
            se_sel_eff = pll_ovr_r[`SE_SEL_BIT];
            c_eff = pll_ovr_r[`C_SEL_MSB:`C_SEL_LSB];
            d_raw = pll_ovr_r[`D_SEL_MSB:`D_SEL_LSB];
        end else begin
            pll_en_eff = pin_r[`PIN_PLL_EN];
            se_sel_eff = pin_r[`PIN_SE_REF];
            c_eff = c_pin;
            d_raw = d_pin;
        end
    end

    assign d_eff = (c_eff == `DIV_OFF) ? `DIV_OFF : d_raw;

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            PLL_ENABLE_O <= 1'b0;
            SINGLE_ENDED_REF_SELECT_O <= 1'b0;
        end else begin
            PLL_ENABLE_O <= pll_en_eff;
            SINGLE_ENDED_REF_SELECT_O <= se_sel_eff;
        end
    end

    tick_divider c_div (
        .clk_i(CLK_SYS_I),
        .rst_n_i(rst_n),
        .tick_i(ref_tick),
        .clr_i(1'b0),
        .mode_i(c_eff),
        .q_o(REF_OUTPUT_C_O)
    );

    tick_divider d_div (
        .clk_i(CLK_SYS_I),
        .rst_n_i(rst_n),
        .tick_i(ref_tick),
        .clr_i(1'b0),
        .mode_i(d_eff),
        .q_o(REF_OUTPUT_D_O)
    );

    // ----------------------------------------------------------------
    // Auxiliary output
    // ----------------------------------------------------------------
    logic aux_en;
    logic [2:0] aux_sel;
    aux_src_type aux_src;
    div_mode_type aux_mode;
    logic ser_q;

    assign aux_en = aux_ctrl_r[`AUX_EN_BIT];
    assign aux_sel = aux_ctrl_r[`AUX_SEL_MSB:`AUX_SEL_LSB];

    // Reserved selects leave the output parked low.
    always_comb begin
        aux_src = AUX_SRC_OFF;
        aux_mode = `DIV_OFF;
        if (aux_en) begin
            unique case (aux_sel)
                `SEL_16UI: begin
                    aux_src = AUX_SRC_SER;
                    aux_mode = `DIV_1;
                end
                `SEL_32UI: begin
                    aux_src = AUX_SRC_SER;
                    aux_mode = `DIV_2;
                end
                `SEL_64UI: begin
                    aux_src = AUX_SRC_SER;
                    aux_mode = `DIV_4;
                end
                `SEL_TSTAMP: aux_src = AUX_SRC_TSTAMP;
                default: aux_src = AUX_SRC_OFF;
            endcase
        end
    end

    // One serializer tick is 8 UI, so half periods of 1, 2, 4 ticks
    // give 16, 32, 64 UI.
    tick_divider aux_div (
        .clk_i(CLK_SYS_I),
        .rst_n_i(rst_n),
        .tick_i(SER_TICK_I),
        .clr_i(SER_REINIT_I),
        .mode_i(aux_mode),
        .q_o(ser_q)
    );

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            AUX_CLOCK_OUTPUT_O <= 1'b0;
        end else if (aux_src == AUX_SRC_TSTAMP) begin
            AUX_CLOCK_OUTPUT_O <= pin_r[`PIN_TSTAMP];
        end else begin
            AUX_CLOCK_OUTPUT_O <= ser_q;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!rst_n);

    aux_cfg_write_a: assert property (
        REG_WE_I && REG_ADDR_I == `AUX_CTRL_ADDR |=> aux_ctrl_r == $past(REG_WDATA_I))
        else $error("aux control write not stored");

    aux_tstamp_path_a: assert property (
        aux_src == AUX_SRC_TSTAMP |=> AUX_CLOCK_OUTPUT_O == $past(pin_r[`PIN_TSTAMP]))
        else $error("aux output does not follow timestamp");

    aux_off_quiet_a: assert property (
        (aux_src == AUX_SRC_OFF && !ser_q)[*2] |=> !AUX_CLOCK_OUTPUT_O)
        else $error("disabled aux output not low");

    aux_reinit_low_a: assert property (
        SER_REINIT_I && aux_src == AUX_SRC_SER ##1 aux_src == AUX_SRC_SER
        |=> !AUX_CLOCK_OUTPUT_O)
        else $error("aux output not disrupted by reinit");

    pll_ovr_value_a: assert property (
        ovr_en |=> PLL_ENABLE_O == $past(pll_ovr_r[`PLL_EN_BIT]))
        else $error("PLL enable ignores override value");

    pll_pin_mode_a: assert property (
        !ovr_en |=> PLL_ENABLE_O == $past(pin_r[`PIN_PLL_EN])
            && SINGLE_ENDED_REF_SELECT_O == $past(pin_r[`PIN_SE_REF]))
        else $error("pin mode not followed");

    se_ovr_value_a: assert property (
        ovr_en |=> SINGLE_ENDED_REF_SELECT_O == $past(pll_ovr_r[`SE_SEL_BIT]))
        else $error("single-ended select ignores override");

    d_needs_c_a: assert property (
        (c_eff == `DIV_OFF && !REF_OUTPUT_D_O)[*2] |=> !REF_OUTPUT_D_O)
        else $error("output D runs without output C");

    c_off_hold_a: assert property (
        (c_eff == `DIV_OFF && !REF_OUTPUT_C_O)[*2] |=> $stable(REF_OUTPUT_C_O))
        else $error("disabled output C moved");

    c_div1_follow_a: assert property (
        c_div.mode_r == `DIV_1 && ref_tick |=> $changed(REF_OUTPUT_C_O))
        else $error("output C misses a divide by one edge");

    d_ovr_mode_a: assert property (
        ovr_en && c_eff != `DIV_OFF |-> d_eff == pll_ovr_r[`D_SEL_MSB:`D_SEL_LSB])
        else $error("output D select not applied");

    unmapped_read_a: assert property (
        REG_RE_I && REG_ADDR_I != `AUX_CTRL_ADDR && REG_ADDR_I != `PLL_OVR_ADDR
        |=> REG_RVALID_O && REG_RDATA_O == `READ_IDLE)
        else $error("unmapped read not zero");

    aux_tstamp_c: cover property (aux_src == AUX_SRC_TSTAMP ##1 AUX_CLOCK_OUTPUT_O);
    aux_64ui_c: cover property (aux_mode == `DIV_4 ##1 $rose(AUX_CLOCK_OUTPUT_O));
    ref_d_run_c: cover property (ovr_en && d_eff == `DIV_2 ##1 $rose(REF_OUTPUT_D_O));
    pin_mode_c: cover property (!ovr_en && c_pin == `DIV_4 ##1 $rose(REF_OUTPUT_C_O));

endmodule
`default_nettype wire

// ### tb/clock_receiver.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Receiver end that measures one clock output in system cycles.
// ----------------------------------------------------------------
module clock_receiver (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clr_i,
    input wire logic sig_i,
    output logic [15:0] hi_len_o,
    output logic [15:0] rises_o
);
    logic last_r;
    logic [15:0] run_r;

    // A high phase cut by a clear is recorded short, so callers settle first.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_r <= 1'b0;
            run_r <= 16'h0000;
            hi_len_o <= 16'h0000;
            rises_o <= 16'h0000;
        end else if (clr_i) begin
            last_r <= sig_i;
            run_r <= 16'h0000;
            hi_len_o <= 16'h0000;
            rises_o <= 16'h0000;
        end else begin
            last_r <= sig_i;
            if (sig_i && !last_r) begin
                rises_o <= rises_o + 16'h0001;
                run_r <= 16'h0001;
            end else if (sig_i) begin
                run_r <= run_r + 16'h0001;
            end
            if (!sig_i && last_r) begin
                hi_len_o <= run_r;
            end
        end
    end
endmodule

`default_nettype wire

// ### tb/aux_clock_output_and_pll_override_bench.sv
`timescale 1ns/1ps
`default_nettype none

module aux_clock_output_and_pll_override_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic we = 1'b0, re = 1'b0, clr = 1'b0, tick = 1'b0, reinit = 1'b0, tstamp = 1'b0;
    logic pll_pin = 1'b0, se_pin = 1'b0, cfg0 = 1'b0, cfg1 = 1'b0, ref_clk = 1'b0;
    logic [7:0] rdata;
    logic rvalid, pll_en, se_sel, out_c, out_d, aux;
    logic [15:0] c_hi, c_n, d_hi, d_n, a_hi, a_n;
    logic [7:0] v;
    logic [1:0] m2, d2;
    int failures = 0;
    int num_checks = 0;

    // ------------------------------------------------------------
    // Clocks, serializer strobe every 2 cycles, reference every 4.
    // ------------------------------------------------------------
    always #25 clk = ~clk;
    always @(posedge clk) tick <= ~tick;
    always begin
        repeat (4) @(posedge clk);
        ref_clk <= ~ref_clk;
    end

    clkout_ctrl clkout_ctrl_i (.CLK_SYS_I(clk), .RESETN_I(rst_n), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WE_I(we), .REG_RE_I(re), .REG_RDATA_O(rdata),
        .REG_RVALID_O(rvalid), .PLL_ENABLE_PIN_I(pll_pin), .SINGLE_ENDED_REF_PIN_I(se_pin),
        .CLOCK_CONFIG_PIN0_I(cfg0), .CLOCK_CONFIG_PIN1_I(cfg1), .PLL_REF_CLOCK_I(ref_clk),
        .TIMESTAMP_INPUT_I(tstamp), .SER_TICK_I(tick), .SER_REINIT_I(reinit),
        .PLL_ENABLE_O(pll_en), .SINGLE_ENDED_REF_SELECT_O(se_sel), .REF_OUTPUT_C_O(out_c),
        .REF_OUTPUT_D_O(out_d), .AUX_CLOCK_OUTPUT_O(aux));
    clock_receiver rx_c (.clk_i(clk), .rst_n_i(rst_n), .clr_i(clr), .sig_i(out_c),
        .hi_len_o(c_hi), .rises_o(c_n));
    clock_receiver rx_d (.clk_i(clk), .rst_n_i(rst_n), .clr_i(clr), .sig_i(out_d),
        .hi_len_o(d_hi), .rises_o(d_n));
    clock_receiver rx_a (.clk_i(clk), .rst_n_i(rst_n), .clr_i(clr), .sig_i(aux),
        .hi_len_o(a_hi), .rises_o(a_n));

    function automatic logic [15:0] ref_hi(input logic [1:0] m);
        return (m == 2'h0) ? 16'h0000 : (16'h0004 << (m - 2'h1));
    endfunction

    function automatic logic [15:0] aux_hi(input logic [2:0] s);
        return 16'h0002 << s;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t ns %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1;
        chk({7'h00, rvalid, rdata}, {8'h01, exp}, "read");
    endtask

    task automatic measure;
        repeat (40) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (80) @(posedge clk);
        #1;
    endtask

    task automatic wrap_up;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence.
    // ------------------------------------------------------------
    initial begin
        v = $urandom(32'h6c6dd10b);
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(8'h57, 8'h00);
        rd(8'h58, 8'h00);
        wr(8'h59, 8'hFF);
        rd(8'h59, 8'h00);
        v = {2'b00, 6'($urandom)};
        wr(8'h58, v);
        rd(8'h58, v);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            v = $urandom;
            @(posedge clk);
            {cfg1, cfg0, se_pin, pll_pin} <= v[3:0];
            measure();
            chk({14'h0, se_sel, pll_en}, {14'h0, v[1:0]}, "pin pll");
            chk(c_hi, ref_hi(v[3:2]), "pin c");
            chk(d_hi, v[3] ? ref_hi(v[3:2]) : 16'h0, "pin d");
        end
        $display("test pin mode done");
        for (int m = 0; m < 4; m++) begin
            v = $urandom;
            m2 = m[1:0];
            d2 = 2'($urandom_range(1, 3));
            @(posedge clk);
            {cfg1, cfg0, se_pin, pll_pin} <= ~v[3:0];
            wr(8'h58, {2'b10, d2, m2, v[1:0]});
            measure();
            chk({14'h0, se_sel, pll_en}, {14'h0, v[1:0]}, "ovr pll");
            chk(c_hi, ref_hi(m2), "ovr c");
            chk(d_hi, (m2 == 2'h0) ? 16'h0 : ref_hi(d2), "ovr d");
        end
        $display("test override done");
        wr(8'h57, 8'h00);
        measure();
        chk(a_n, 16'h0, "aux off");
        for (int s = 0; s < 3; s++) begin
            wr(8'h57, 8'(s));
            wr(8'h57, 8'h80 | 8'(s));
            measure();
            chk(a_hi, aux_hi(3'(s)), "aux sel");
        end
        @(posedge clk);
        reinit <= 1'b1;
        measure();
        chk(a_n, 16'h0, "reinit");
        @(posedge clk);
        reinit <= 1'b0;
        measure();
        chk(a_hi, aux_hi(3'h2), "restart");
        wr(8'h57, 8'h00);
        wr(8'h57, 8'h03);
        wr(8'h57, 8'h83);
        for (int i = 0; i < 6; i++) begin
            v = $urandom;
            @(posedge clk);
            tstamp <= v[0];
            repeat (6) @(posedge clk);
            #1;
            chk({15'h0, aux}, {15'h0, v[0]}, "tstamp");
        end
        wr(8'h57, 8'h00);
        wr(8'h57, 8'h04);
        wr(8'h57, 8'h84);
        measure();
        chk(a_n, 16'h0, "reserved sel");
        $display("test aux done");
        wrap_up();
    end

    initial begin
        repeat (10000) @(posedge clk);
        failures++;
        wrap_up();
    end
endmodule

`default_nettype wire
